// >>> logic/clsf_defines.svh
// constants for the computer link status flag block
// assumes a single 125 MHz controller clock and no register bus
// Function
// - each channel raises its own link error flag on any communication error
// - the matching error code is written when the channel error flag rises
// - error flag stays set after traffic recovers; good traffic never clears it
// - errors clear at power-up on newer parts, on stop-to-run on older parts
// - stored error code changes only on a later error or at that variant's clear condition
// - character fault stores 6301 on channel 1, 3801 on channel 2
// - broadcast station FF with non-global-write stores 6305 or 3805
// - message timeout reinitialises receive and stores 6306 or 3806
// - oldest part keeps channel 1 format and station only while keep bit is set
// - global write command sets or clears the channel global flag
// - global flag forced off at power-down or in stop mode
// - on-demand busy set on request, held until sending completes
// - on-demand fault set when the requested data quantity is invalid
// - fault blocks on-demand sends; program clears it before a new request
// - unit select set picks 8-bit bytes, clear picks 16-bit words
// - word mode one register per unit; byte mode units halved rounded up
// - newer parts load format from parameters at power-up, older from program
// - channel 2 format comes from parameters; its word is only for reading
// - per-channel timeout word sets allowed pause in a reception
`ifndef CLSF_DEFINES_SVH
`define CLSF_DEFINES_SVH
`define CLSF_NCH 2
`define CLSF_CODE_CHAR_CH1 16'h6301
`define CLSF_CODE_CMD_CH1 16'h6305
`define CLSF_CODE_TMO_CH1 16'h6306
`define CLSF_CODE_CHAR_CH2 16'h3801
`define CLSF_CODE_CMD_CH2 16'h3805
`define CLSF_CODE_TMO_CH2 16'h3806
`define CLSF_CODE_NONE 16'h0000
`define CLSF_BCAST_STATION 8'hFF
`define CLSF_STATION_RESET 8'h00
`define CLSF_FMT_RESET 16'h0000
`define CLSF_OD_MIN_UNITS 16'h0001
`define CLSF_OD_MAX_UNITS 16'h0040
`define CLSF_CLK_PERIOD_NS 8
`define CLSF_TMO_UNIT_NS 10000000
`define CLSF_TICK_CYCLES (`CLSF_TMO_UNIT_NS / `CLSF_CLK_PERIOD_NS)
`define CLSF_TMO_OFF 16'h0000
`endif

// >>> logic/clsf_err_if.sv
// carrier between the channel logic and its error recorder
// assumes one clock domain; all signals are same-clock logic
`timescale 1ns/1ps
`default_nettype none
interface clsf_err_if;
  import clsf_pkg::*;
  logic evt;
  clsf_word_type code_in;
  logic clear;
  logic flag;
  clsf_word_type code;
  modport src (output evt, output code_in, output clear,
    input flag, input code);
  modport rec (input evt, input code_in, input clear,
    output flag, output code);
endinterface
`default_nettype wire

// >>> logic/clsf_err_recorder.sv
// sticky error flag and error code word of one channel
// assumes evt and clear are one-cycle pulses on clk
`timescale 1ns/1ps
`default_nettype none
`include "clsf_defines.svh"
module clsf_err_recorder (
  input wire logic clk,
  input wire logic reset_n,
  clsf_err_if.rec err
);
  import clsf_pkg::*;

  // an error in the clearing cycle wins over the clear
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      err.flag <= 1'b0;
    end else if (err.evt) begin
      err.flag <= 1'b1;
    end else if (err.clear) begin
      err.flag <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      err.code <= `CLSF_CODE_NONE;
    end else if (err.evt) begin
      err.code <= err.code_in;
    end else if (err.clear) begin
      err.code <= `CLSF_CODE_NONE;
    end
  end
endmodule
`default_nettype wire

// >>> logic/clsf_link_flags.sv
// status and control flags of a two-channel computer link
// assumes all inputs come from logic on clk; channel events are pulses
`timescale 1ns/1ps
`default_nettype none
`include "clsf_defines.svh"
module clsf_link_flags #(
  parameter int TICK_CYCLES = `CLSF_TICK_CYCLES
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic run_mode,
  input wire logic variant_powerup_clear,
  input wire logic variant_param_format,
  input wire logic variant_oldest,
  input wire logic setting_keep_bit,
  input wire clsf_pkg::clsf_word_type param_format_ch1,
  input wire clsf_pkg::clsf_word_type param_format_ch2,
  input wire clsf_pkg::clsf_station_type param_station_ch1,
  input wire clsf_pkg::clsf_station_type param_station_ch2,
  input wire logic format_wr_en,
  input wire clsf_pkg::clsf_word_type format_wr_data,
  input wire logic station_wr_en,
  input wire clsf_pkg::clsf_station_type station_wr_data,
  input wire logic rx_char_ch1,
  input wire logic rx_char_ch2,
  input wire logic rx_char_fault_ch1,
  input wire logic rx_char_fault_ch2,
  input wire logic frame_valid_ch1,
  input wire logic frame_valid_ch2,
  input wire clsf_pkg::clsf_station_type frame_station_ch1,
  input wire clsf_pkg::clsf_station_type frame_station_ch2,
  input wire logic global_write_command_ch1,
  input wire logic global_write_command_ch2,
  input wire logic global_write_on_ch1,
  input wire logic global_write_on_ch2,
  input wire clsf_pkg::clsf_word_type rx_timeout_word_ch1,
  input wire clsf_pkg::clsf_word_type rx_timeout_word_ch2,
  input wire logic od_req_ch1,
  input wire logic od_req_ch2,
  input wire clsf_pkg::clsf_word_type od_qty_ch1,
  input wire clsf_pkg::clsf_word_type od_qty_ch2,
  input wire logic ondemand_unit_sel_ch1,
  input wire logic ondemand_unit_sel_ch2,
  input wire logic od_fault_clr_ch1,
  input wire logic od_fault_clr_ch2,
  input wire logic od_send_done_ch1,
  input wire logic od_send_done_ch2,
  output logic link_error_flag_ch1,
  output logic link_error_flag_ch2,
  output clsf_pkg::clsf_word_type link_error_code_ch1,
  output clsf_pkg::clsf_word_type link_error_code_ch2,
  output logic global_flag_ch1,
  output logic global_flag_ch2,
  output logic ondemand_busy_ch1,
  output logic ondemand_busy_ch2,
  output logic ondemand_fault_ch1,
  output logic ondemand_fault_ch2,
  output logic od_start_ch1,
  output logic od_start_ch2,
  output clsf_pkg::clsf_word_type od_reg_count_ch1,
  output clsf_pkg::clsf_word_type od_reg_count_ch2,
  output logic rx_reinit_ch1,
  output logic rx_reinit_ch2,
  output clsf_pkg::clsf_word_type comm_format_word_ch1,
  output clsf_pkg::clsf_word_type comm_format_word_ch2,
  output clsf_pkg::clsf_station_type station_word_ch1,
  output clsf_pkg::clsf_station_type station_word_ch2
);
  import clsf_pkg::*;

  localparam int NCH = `CLSF_NCH;

  function automatic clsf_word_type err_code(input int ch,
    input clsf_err_kind_type kind);
    clsf_word_type c;
    c = `CLSF_CODE_NONE;
    case (kind)
      CLSF_ERR_CHAR: c = (ch == 0) ? `CLSF_CODE_CHAR_CH1
                                   : `CLSF_CODE_CHAR_CH2;
      CLSF_ERR_CMD: c = (ch == 0) ? `CLSF_CODE_CMD_CH1
                                  : `CLSF_CODE_CMD_CH2;
      CLSF_ERR_TMO: c = (ch == 0) ? `CLSF_CODE_TMO_CH1
                                  : `CLSF_CODE_TMO_CH2;
      default: c = `CLSF_CODE_NONE;
    endcase
    return c;
  endfunction

  // per-channel views of the plain ports
  logic [NCH-1:0] rx_char, char_fault, frame_valid, gw_cmd, gw_on;
  logic [NCH-1:0] od_req, unit_sel, od_fault_clr, od_done;
  clsf_station_type frame_station [NCH];
  clsf_station_type own_station [NCH];
  clsf_word_type tmo_word [NCH];
  clsf_word_type od_qty [NCH];
  logic [NCH-1:0] global_reg, busy_reg, fault_reg, start_reg, reinit_reg;
  clsf_word_type reg_count_reg [NCH];
  logic [NCH-1:0] err_flag;
  clsf_word_type err_code_word [NCH];

  assign rx_char = {rx_char_ch2, rx_char_ch1};
  assign char_fault = {rx_char_fault_ch2, rx_char_fault_ch1};
  assign frame_valid = {frame_valid_ch2, frame_valid_ch1};
  assign gw_cmd = {global_write_command_ch2, global_write_command_ch1};
  assign gw_on = {global_write_on_ch2, global_write_on_ch1};
  assign od_req = {od_req_ch2, od_req_ch1};
  assign unit_sel = {ondemand_unit_sel_ch2, ondemand_unit_sel_ch1};
  assign od_fault_clr = {od_fault_clr_ch2, od_fault_clr_ch1};
  assign od_done = {od_send_done_ch2, od_send_done_ch1};
  assign frame_station[0] = frame_station_ch1;
  assign frame_station[1] = frame_station_ch2;
  assign tmo_word[0] = rx_timeout_word_ch1;
  assign tmo_word[1] = rx_timeout_word_ch2;
  assign od_qty[0] = od_qty_ch1;
  assign od_qty[1] = od_qty_ch2;
  assign own_station[0] = station_word_ch1;
  assign own_station[1] = station_word_ch2;

  // mode tracking and power-up parameter load
  logic run_prev_reg, load_pending_reg;
  logic stop_to_run;
  assign stop_to_run = run_mode & ~run_prev_reg;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      run_prev_reg <= 1'b1;
    end else begin
      run_prev_reg <= run_mode;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      load_pending_reg <= 1'b1;
    end else begin
      load_pending_reg <= 1'b0;
    end
  end

  // older parts clear errors on stop-to-run; newer parts only at reset
  logic err_clear;
  assign err_clear = stop_to_run & ~variant_powerup_clear;

  // oldest part drops its channel 1 settings on stop-to-run unless told to keep them
  logic settings_drop;
  assign settings_drop = variant_oldest & ~setting_keep_bit
    & stop_to_run;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      comm_format_word_ch1 <= `CLSF_FMT_RESET;
    end else if (load_pending_reg && variant_param_format) begin
      comm_format_word_ch1 <= param_format_ch1;
    end else if (format_wr_en && !variant_param_format) begin
      comm_format_word_ch1 <= format_wr_data;
    end else if (settings_drop) begin
      comm_format_word_ch1 <= `CLSF_FMT_RESET;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      station_word_ch1 <= `CLSF_STATION_RESET;
    end else if (load_pending_reg && variant_param_format) begin
      station_word_ch1 <= param_station_ch1;
    end else if (station_wr_en && !variant_param_format) begin
      station_word_ch1 <= station_wr_data;
    end else if (settings_drop) begin
      station_word_ch1 <= `CLSF_STATION_RESET;
    end
  end

  // channel 2 settings come only from parameters; program writes ignored
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      comm_format_word_ch2 <= `CLSF_FMT_RESET;
      station_word_ch2 <= `CLSF_STATION_RESET;
    end else if (load_pending_reg) begin
      comm_format_word_ch2 <= param_format_ch2;
      station_word_ch2 <= param_station_ch2;
    end
  end

  // timeout time base: one enable pulse per timeout unit
  logic [31:0] tick_cnt_reg;
  logic tick;
  assign tick = (tick_cnt_reg == 32'(TICK_CYCLES - 1));

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      tick_cnt_reg <= 32'h0000_0000;
    end else if (tick) begin
      tick_cnt_reg <= 32'h0000_0000;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 32'h0000_0001;
    end
  end

  genvar ch;
  generate
    for (ch = 0; ch < NCH; ch++) begin : g_ch
      clsf_err_if err_bus ();
      clsf_rx_state_type rx_state_reg;
      clsf_word_type tmo_cnt_reg;
      logic tmo_hit, for_me, bcast, cmd_err, od_bad, od_ok;

      assign for_me = frame_valid[ch]
        && (frame_station[ch] == own_station[ch]);
      assign bcast = frame_valid[ch]
        && (frame_station[ch] == `CLSF_BCAST_STATION);
      assign cmd_err = bcast && !gw_cmd[ch];
      assign tmo_hit = (rx_state_reg == CLSF_RX_BUSY)
        && (tmo_word[ch] != `CLSF_TMO_OFF)
        && (tmo_cnt_reg >= tmo_word[ch]);

      // watch for a reception that stalls before its message completes
      always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
          rx_state_reg <= CLSF_RX_IDLE;
          tmo_cnt_reg <= 16'h0000;
        end else begin
          case (rx_state_reg)
            CLSF_RX_IDLE: begin
              tmo_cnt_reg <= 16'h0000;
              if (rx_char[ch] && !frame_valid[ch]) begin
                rx_state_reg <= CLSF_RX_BUSY;
              end
            end
            CLSF_RX_BUSY: begin
              if (frame_valid[ch] || tmo_hit) begin
                rx_state_reg <= CLSF_RX_IDLE;
                tmo_cnt_reg <= 16'h0000;
              end else if (rx_char[ch]) begin
                tmo_cnt_reg <= 16'h0000;
              end else if (tick) begin
                tmo_cnt_reg <= tmo_cnt_reg + 16'h0001;
              end
            end
            default: begin
              rx_state_reg <= CLSF_RX_IDLE;
              tmo_cnt_reg <= 16'h0000;
            end
          endcase
        end
      end

      always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
          reinit_reg[ch] <= 1'b0;
        end else begin
          reinit_reg[ch] <= tmo_hit;
        end
      end

      // character faults take priority over command and timeout codes
      assign err_bus.evt = char_fault[ch] | cmd_err | tmo_hit;
      assign err_bus.code_in = char_fault[ch]
        ? err_code(ch, CLSF_ERR_CHAR)
        : cmd_err ? err_code(ch, CLSF_ERR_CMD)
        : err_code(ch, CLSF_ERR_TMO);
      assign err_bus.clear = err_clear;
      assign err_flag[ch] = err_bus.flag;
      assign err_code_word[ch] = err_bus.code;

      clsf_err_recorder u_rec (
        .clk(clk),
        .reset_n(reset_n),
        .err(err_bus)
      );

      // global flag follows the global write; stop mode forces it off
      always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
          global_reg[ch] <= 1'b0;
        end else if (!run_mode) begin
          global_reg[ch] <= 1'b0;
        end else if ((for_me || bcast) && gw_cmd[ch]) begin
          global_reg[ch] <= gw_on[ch];
        end
      end

      assign od_bad = (od_qty[ch] < `CLSF_OD_MIN_UNITS)
        || (od_qty[ch] > `CLSF_OD_MAX_UNITS);
      // a request while busy is dropped; the program interlocks on busy
      assign od_ok = od_req[ch] && !od_bad && !fault_reg[ch]
        && !busy_reg[ch];

      always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
          fault_reg[ch] <= 1'b0;
        end else if (od_req[ch] && od_bad) begin
          fault_reg[ch] <= 1'b1;
        end else if (od_fault_clr[ch]) begin
          fault_reg[ch] <= 1'b0;
        end
      end

      always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
          busy_reg[ch] <= 1'b0;
        end else if (od_ok) begin
          busy_reg[ch] <= 1'b1;
        end else if (od_done[ch]) begin
          busy_reg[ch] <= 1'b0;
        end
      end

      always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
          start_reg[ch] <= 1'b0;
        end else begin
          start_reg[ch] <= od_ok;
        end
      end

      always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
          reg_count_reg[ch] <= 16'h0000;
        end else if (od_ok) begin
          reg_count_reg[ch] <= unit_sel[ch]
            ? ((od_qty[ch] >> 1) + {15'h0000, od_qty[ch][0]})
            : od_qty[ch];
        end
      end
    end
  endgenerate

  assign link_error_flag_ch1 = err_flag[0];
  assign link_error_flag_ch2 = err_flag[1];
  assign link_error_code_ch1 = err_code_word[0];
  assign link_error_code_ch2 = err_code_word[1];
  assign global_flag_ch1 = global_reg[0];
  assign global_flag_ch2 = global_reg[1];
  assign ondemand_busy_ch1 = busy_reg[0];
  assign ondemand_busy_ch2 = busy_reg[1];
  assign ondemand_fault_ch1 = fault_reg[0];
  assign ondemand_fault_ch2 = fault_reg[1];
  assign od_start_ch1 = start_reg[0];
  assign od_start_ch2 = start_reg[1];
  assign od_reg_count_ch1 = reg_count_reg[0];
  assign od_reg_count_ch2 = reg_count_reg[1];
  assign rx_reinit_ch1 = reinit_reg[0];
  assign rx_reinit_ch2 = reinit_reg[1];
endmodule
`default_nettype wire

// >>> logic/clsf_pkg.sv
// types shared by the computer link status flag block
// assumes clsf_defines.svh for all numeric constants
package clsf_pkg;
  typedef logic [15:0] clsf_word_type;
  typedef logic [7:0] clsf_station_type;
  typedef enum logic {CLSF_RX_IDLE, CLSF_RX_BUSY} clsf_rx_state_type;
  typedef enum logic [1:0] {CLSF_ERR_CHAR, CLSF_ERR_CMD, CLSF_ERR_TMO}
    clsf_err_kind_type;
endpackage

// >>> test/clsf_host_model.sv
// host computer side of one link channel: characters and framed commands
// assumes tasks are called from the bench; changes land on falling clk
`timescale 1ns/1ps
`default_nettype none
module clsf_host_model (
  input wire logic clk,
  output logic rx_char,
  output logic rx_char_fault,
  output logic frame_valid,
  output clsf_pkg::clsf_station_type frame_station,
  output logic gw_cmd,
  output logic gw_on
);
  import clsf_pkg::*;
  initial begin
    {rx_char, rx_char_fault, frame_valid} = 3'h0;
    frame_station = 8'h00;
    gw_cmd = 1'b1;
    gw_on = 1'b1;
  end
  task automatic chr(input logic bad);
    rx_char <= 1'b1;
    rx_char_fault <= bad;
    @(negedge clk);
    rx_char <= 1'b0;
    rx_char_fault <= 1'b0;
  endtask
  // idle edge first; scramble fields once frame_valid drops
  task automatic frm(input clsf_station_type st, input logic gw,
      input logic on);
    @(negedge clk);
    frame_valid <= 1'b1;
    frame_station <= st;
    gw_cmd <= gw;
    gw_on <= on;
    @(negedge clk);
    frame_valid <= 1'b0;
    frame_station <= ~st;
    gw_cmd <= ~gw;
    gw_on <= ~on;
  endtask
endmodule
`default_nettype wire

// >>> test/clsf_link_flags_chk.sv
// port-level assertions for the link status flag block, channel 1
// assumes bind to clsf_link_flags; one clock, reset_n async low
`timescale 1ns/1ps
`default_nettype none
module clsf_link_flags_chk (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic run_mode,
  input wire logic variant_powerup_clear,
  input wire logic rx_char_fault_ch1,
  input wire logic frame_valid_ch1,
  input wire clsf_pkg::clsf_station_type frame_station_ch1,
  input wire logic global_write_command_ch1,
  input wire logic global_write_on_ch1,
  input wire logic od_req_ch1,
  input wire clsf_pkg::clsf_word_type od_qty_ch1,
  input wire logic ondemand_unit_sel_ch1,
  input wire logic od_send_done_ch1,
  input wire logic link_error_flag_ch1,
  input wire clsf_pkg::clsf_word_type link_error_code_ch1,
  input wire logic global_flag_ch1,
  input wire logic ondemand_busy_ch1,
  input wire logic ondemand_fault_ch1,
  input wire logic od_start_ch1,
  input wire clsf_pkg::clsf_word_type od_reg_count_ch1,
  input wire logic rx_reinit_ch1
);
  import clsf_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  char_fault_a: assert property (
    rx_char_fault_ch1 |=> link_error_flag_ch1 &&
    link_error_code_ch1 == 16'h6301)
    else $error("char fault not recorded");
  bcast_cmd_a: assert property (
    frame_valid_ch1 && frame_station_ch1 == 8'hFF &&
    !global_write_command_ch1 && !rx_char_fault_ch1 |=>
    link_error_flag_ch1 && link_error_code_ch1 == 16'h6305)
    else $error("broadcast command error not recorded");
  flag_sticky_a: assert property (
    link_error_flag_ch1 && variant_powerup_clear |=> link_error_flag_ch1)
    else $error("error flag dropped");
  code_cause_a: assert property (
    $changed(link_error_code_ch1) |-> link_error_code_ch1 == 16'h0000 ||
    rx_reinit_ch1 || $past(rx_char_fault_ch1) || $past(frame_valid_ch1))
    else $error("error code changed without cause");
  tmo_code_a: assert property (
    rx_reinit_ch1 && !$past(rx_char_fault_ch1) && !$past(frame_valid_ch1)
    |-> link_error_flag_ch1 && link_error_code_ch1 == 16'h6306)
    else $error("timeout without its code");
  gw_load_a: assert property (
    run_mode && frame_valid_ch1 && global_write_command_ch1 &&
    frame_station_ch1 == 8'hFF |=> global_flag_ch1 == $past(global_write_on_ch1))
    else $error("global flag not loaded");
  gw_stop_a: assert property (
    !run_mode |=> !global_flag_ch1)
    else $error("global flag kept in stop");
  od_accept_a: assert property (
    od_req_ch1 && !ondemand_busy_ch1 && !ondemand_fault_ch1 &&
    od_qty_ch1 inside {[16'h0001:16'h0040]} |=> od_start_ch1 &&
    ondemand_busy_ch1 && od_reg_count_ch1 == ($past(ondemand_unit_sel_ch1) ?
    ($past(od_qty_ch1) + 16'h0001) >> 1 : $past(od_qty_ch1)))
    else $error("on-demand request not accepted");
  od_bad_qty_a: assert property (
    od_req_ch1 && !ondemand_busy_ch1 && (od_qty_ch1 == 16'h0000 ||
    od_qty_ch1 > 16'h0040) |=> ondemand_fault_ch1 && !od_start_ch1)
    else $error("bad quantity not flagged");
  od_block_a: assert property (
    ondemand_fault_ch1 |=> !od_start_ch1)
    else $error("send started during fault");
  busy_track_a: assert property (
    ondemand_busy_ch1 |=> ondemand_busy_ch1 == !$past(od_send_done_ch1))
    else $error("busy flag wrong");
endmodule
`default_nettype wire

// >>> test/clsf_link_flags_tb_top.sv
// self-checking bench for the computer link status flag block
// assumes package, defines header, host model and checker compiled first
`timescale 1ns/1ps
`default_nettype none
`include "clsf_defines.svh"
module clsf_link_flags_tb_top;
  import clsf_pkg::*;
  localparam int TICKS = 4;
  localparam clsf_word_type PF = 16'h1A5C;
  localparam clsf_station_type PS = 8'h05;
  logic clk = 1'b0, reset_n = 1'b0, run_mode = 1'b1, v_pclr = 1'b1;
  logic v_pfmt = 1'b1, v_old = 1'b0, keep = 1'b0, fmt_we = 1'b0;
  logic st_we = 1'b0, rq = 1'b0, us = 1'b0, fc = 1'b0, dn = 1'b0;
  clsf_word_type fmt_wd = 16'h2C81, tmo1 = 16'h0000, tmo2 = 16'h0000;
  clsf_word_type q = 16'h0001;
  clsf_station_type st_wd = 8'h0A;
  logic rc1, rc2, rf1, rf2, fv1, fv2, gw1, gw2, on1, on2;
  logic ef1, ef2, gf1, gf2, b1, b2, f1, f2, s1, s2, ri1, ri2;
  clsf_station_type fs1, fs2, sw1, sw2;
  clsf_word_type ec1, ec2, n1, n2, cf1, cf2;
  int fail_count = 0, cmp_count = 0;
  always #4 clk = ~clk;
  clsf_host_model host_ch1 (.clk(clk), .rx_char(rc1), .rx_char_fault(rf1),
    .frame_valid(fv1), .frame_station(fs1), .gw_cmd(gw1), .gw_on(on1));
  clsf_host_model host_ch2 (.clk(clk), .rx_char(rc2), .rx_char_fault(rf2),
    .frame_valid(fv2), .frame_station(fs2), .gw_cmd(gw2), .gw_on(on2));
  clsf_link_flags #(.TICK_CYCLES(TICKS)) clsf_link_flags_i (
    .clk(clk), .reset_n(reset_n), .run_mode(run_mode),
    .variant_powerup_clear(v_pclr), .variant_param_format(v_pfmt),
    .variant_oldest(v_old), .setting_keep_bit(keep),
    .param_format_ch1(PF), .param_format_ch2(fmt_wd),
    .param_station_ch1(PS), .param_station_ch2(st_wd),
    .format_wr_en(fmt_we), .format_wr_data(fmt_wd),
    .station_wr_en(st_we), .station_wr_data(st_wd),
    .rx_char_ch1(rc1), .rx_char_ch2(rc2),
    .rx_char_fault_ch1(rf1), .rx_char_fault_ch2(rf2),
    .frame_valid_ch1(fv1), .frame_valid_ch2(fv2),
    .frame_station_ch1(fs1), .frame_station_ch2(fs2),
    .global_write_command_ch1(gw1), .global_write_command_ch2(gw2),
    .global_write_on_ch1(on1), .global_write_on_ch2(on2),
    .rx_timeout_word_ch1(tmo1), .rx_timeout_word_ch2(tmo2),
    .od_req_ch1(rq), .od_req_ch2(rq), .od_qty_ch1(q), .od_qty_ch2(q),
    .ondemand_unit_sel_ch1(us), .ondemand_unit_sel_ch2(us),
    .od_fault_clr_ch1(fc), .od_fault_clr_ch2(fc),
    .od_send_done_ch1(dn), .od_send_done_ch2(dn),
    .link_error_flag_ch1(ef1), .link_error_flag_ch2(ef2),
    .link_error_code_ch1(ec1), .link_error_code_ch2(ec2),
    .global_flag_ch1(gf1), .global_flag_ch2(gf2),
    .ondemand_busy_ch1(b1), .ondemand_busy_ch2(b2),
    .ondemand_fault_ch1(f1), .ondemand_fault_ch2(f2),
    .od_start_ch1(s1), .od_start_ch2(s2),
    .od_reg_count_ch1(n1), .od_reg_count_ch2(n2),
    .rx_reinit_ch1(ri1), .rx_reinit_ch2(ri2),
    .comm_format_word_ch1(cf1), .comm_format_word_ch2(cf2),
    .station_word_ch1(sw1), .station_word_ch2(sw2));
  task automatic chk(input string what, input logic [15:0] exp,
      input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic tap(ref logic s);
    s = 1'b1;
    @(negedge clk);
    s = 1'b0;
  endtask
  task automatic do_reset();
    reset_n = 1'b0;
    repeat (20) @(negedge clk);
    reset_n = 1'b1;
    repeat (2) @(negedge clk);
  endtask
  task automatic stop_run();
    run_mode = 1'b0;
    repeat (2) @(negedge clk);
    run_mode = 1'b1;
    repeat (3) @(negedge clk);
  endtask
  task automatic req(input clsf_word_type qty, input logic bm);
    @(negedge clk);
    q = qty;
    us = bm;
    tap(rq);
  endtask
  task automatic t_errors();
    chk("fmt1 param", PF, cf1);
    chk("fmt2 param", 16'h2C81, cf2);
    chk("stn1 param", {8'h00, PS}, {8'h00, sw1});
    chk("stn2 param", 16'h000A, {8'h00, sw2});
    host_ch1.chr(1'b1);
    chk("err1 code", `CLSF_CODE_CHAR_CH1, ec1);
    chk("err2 quiet", 0, ef2);
    host_ch2.chr(1'b1);
    chk("err2 code", `CLSF_CODE_CHAR_CH2, ec2);
    host_ch1.frm(8'hFF, 1'b0, 1'b0);
    chk("cmd1 code", `CLSF_CODE_CMD_CH1, ec1);
    host_ch2.frm(8'hFF, 1'b0, 1'b0);
    chk("cmd2 code", `CLSF_CODE_CMD_CH2, ec2);
    host_ch1.frm(PS, 1'b0, 1'b0);
    repeat (3) @(negedge clk);
    chk("sticky flag", 1, ef1);
    chk("sticky code", `CLSF_CODE_CMD_CH1, ec1);
  endtask
  task automatic t_timeout();
    int n, s2 = 0;
    tmo1 = 16'h0002;
    tmo2 = 16'h0001;
    host_ch1.chr(1'b0);
    host_ch1.frm(PS, 1'b0, 1'b0);
    repeat (4 * TICKS) @(negedge clk);
    chk("no timeout", `CLSF_CODE_CMD_CH1, ec1);
    host_ch2.chr(1'b0);
    host_ch1.chr(1'b0);
    n = 0;
    while (ri1 !== 1'b1 && n < 100) begin
      s2 += ri2;
      @(negedge clk);
      n++;
    end
    chk("tmo wait", 1, ri1 === 1'b1 && n >= TICKS);
    if (n == 100) stop_test();
    chk("tmo code1", `CLSF_CODE_TMO_CH1, ec1);
    chk("tmo pulse2", 1, s2 == 1);
    chk("tmo code2", `CLSF_CODE_TMO_CH2, ec2);
  endtask
  task automatic t_clear();
    stop_run();
    chk("kept code", `CLSF_CODE_TMO_CH1, ec1);
    chk("kept flag", 1, ef1);
    v_pclr = 1'b0;
    stop_run();
    chk("clr flag1", 0, ef1);
    chk("clr code1", 0, ec1);
    chk("clr code2", 0, ec2);
    v_pclr = 1'b1;
  endtask
  task automatic t_global();
    host_ch1.frm(8'hFF, 1'b1, 1'b1);
    chk("gw on bcast", 1, gf1);
    chk("gw no error", 0, ef1);
    host_ch1.frm(PS, 1'b1, 1'b0);
    chk("gw off own", 0, gf1);
    host_ch1.frm(PS, 1'b1, 1'b1);
    host_ch1.frm(8'h33, 1'b1, 1'b0);
    chk("gw other stn", 1, gf1);
    host_ch2.frm(8'hFF, 1'b1, 1'b1);
    chk("gw ch2", 1, gf2);
    run_mode = 1'b0;
    repeat (2) @(negedge clk);
    chk("gw stop", 0, gf1 | gf2);
    host_ch1.frm(8'hFF, 1'b1, 1'b1);
    chk("gw in stop", 0, gf1);
    run_mode = 1'b1;
  endtask
  task automatic t_od();
    req(16'h0005, 1'b1);
    chk("od start", 1, s1 & s2 & b1 & b2);
    chk("od count1", 16'h0003, n1);
    chk("od count2", 16'h0003, n2);
    req(16'h0007, 1'b0);
    chk("od drop", 16'h0003, n1);
    tap(dn);
    chk("od done", 0, b1 | b2);
    req(16'h0040, 1'b0);
    chk("od count word", 16'h0040, n1);
    tap(dn);
    req(16'h0041, 1'b0);
    chk("od fault", 1, f1 & f2 & !s1);
    req(16'h0003, 1'b1);
    chk("od blocked", 0, s1 | b1);
    tap(fc);
    chk("od fault clr", 0, f1);
    req(16'h0000, 1'b1);
    chk("od zero", 1, f1);
    tap(fc);
    req(16'h0001, 1'b1);
    chk("od count one", 16'h0001, n1);
    tap(dn);
  endtask
  task automatic t_format();
    v_pfmt = 1'b0;
    fmt_wd = 16'h4B07;
    do_reset();
    chk("fmt no param", 0, cf1);
    tap(fmt_we);
    tap(st_we);
    chk("fmt written", 16'h4B07, cf1);
    chk("stn written", 16'h000A, {8'h00, sw1});
    fmt_wd = 16'h0F0F;
    tap(fmt_we);
    chk("fmt2 only param", 16'h4B07, cf2);
    v_old = 1'b1;
    keep = 1'b1;
    stop_run();
    chk("fmt kept", 16'h0F0F, cf1);
    keep = 1'b0;
    stop_run();
    chk("fmt dropped", 0, cf1 | {8'h00, sw1});
  endtask
  initial begin
    do_reset();
    t_errors();
    $display("error flag test done");
    t_timeout();
    $display("timeout test done");
    t_clear();
    $display("clear test done");
    t_global();
    $display("global flag test done");
    t_od();
    $display("on-demand test done");
    t_format();
    $display("format test done");
    stop_test();
  end
endmodule
bind clsf_link_flags clsf_link_flags_chk clsf_link_flags_chk_i (.clk,
  .reset_n, .run_mode, .variant_powerup_clear, .rx_char_fault_ch1,
  .frame_valid_ch1, .frame_station_ch1, .global_write_command_ch1,
  .global_write_on_ch1, .od_req_ch1, .od_qty_ch1, .ondemand_unit_sel_ch1,
  .od_send_done_ch1, .link_error_flag_ch1, .link_error_code_ch1,
  .global_flag_ch1, .ondemand_busy_ch1, .ondemand_fault_ch1, .od_start_ch1,
  .od_reg_count_ch1, .rx_reinit_ch1);
`default_nettype wire
